/* hw/rbl_params.svh */
/*
 * Constants for the reset and boot-mode loader: register offsets, field
 * positions, reset values and cycle counts.
 * Assumes inclusion by bare name from files under hw/.
 */
`ifndef RBL_PARAMS_SVH
`define RBL_PARAMS_SVH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define RBL_OFS_CTRL       12'h000
`define RBL_OFS_STATUS     12'h004
`define RBL_OFS_MODE       12'h008

// ****************************************
// Register fields
// ****************************************
`define RBL_CTRL_CLR_BIT   0
`define RBL_STAT_DONE_BIT  0
`define RBL_STAT_COLD_BIT  1
`define RBL_STAT_WARM_BIT  2
`define RBL_STAT_RSV_BIT   3
`define RBL_STAT_ST_LSB    4

// ****************************************
// Boot stream layout
// ****************************************
`define RBL_BOOT_BITS      256
`define RBL_MODE_BITS      15
`define RBL_MODE_RESET     15'h0000

// ****************************************
// Timing counts in system clock cycles, then mode decode codes and limits
// ****************************************
`define RBL_SCLK_DIV       256
`define RBL_PLL_LOCK_CYC   64
`define RBL_MULT_BASE      4'h2
`define RBL_MULT_RSV       3'h7
`define RBL_WRATE_MAX      4'h8
`define RBL_NBW_RSV        2'h1

`endif

/* hw/rbl_pkg.sv */
/*
 * Types shared by the reset and boot-mode loader.
 * Assumes rbl_params.svh for the numbers; holds types only.
 */
package rbl_pkg;

	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [2:0] {
		RBL_OFF  = 3'h0,
		RBL_BOOT = 3'h1,
		RBL_LOCK = 3'h2,
		RBL_HELD = 3'h3,
		RBL_RSTW = 3'h4,
		RBL_RUN  = 3'h5
	} rbl_state_t;

	// ****************************************
	// Boot word, bit 14 down to bit 0
	// ****************************************
	typedef struct packed {
		logic [1:0] drive;
		logic       bus32;
		logic       tmr_dis;
		logic [1:0] nbw;
		logic       big_end;
		logic [2:0] mult;
		logic [3:0] wrate;
		logic       rsv0;
	} rbl_mode_t;

	// ****************************************
	// Decoded operating configuration
	// ****************************************
	typedef struct packed {
		logic [3:0] pll_mult;
		logic       big_end;
		logic       timer_route;
		logic       bus32;
		logic [6:0] drive_pct;
		logic [1:0] nbw;
		logic [1:0] wr_run;
		logic [2:0] wr_idle;
		logic       rsv_err;
	} rbl_cfg_t;

	// ****************************************
	// Reset and enable controls toward the core
	// ****************************************
	typedef struct packed {
		logic pll_enable;
		logic sm_reset;
		logic exc_reset;
		logic exc_soft;
		logic bus_oe;
		logic out_oe;
	} rbl_ctl_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} rbl_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} rbl_apb_rsp_t;

endpackage

/* hw/rbl_sync.sv */
/*
 * Three-stage input synchroniser; output moves when stages two and three agree.
 * Assumes inputs from pins or other clocks; outputs are on mclk_i.
 */
`timescale 1ns/1ps
`include "rbl_params.svh"

module rbl_sync #(
	parameter int          W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         mclk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} rbl_sync_t;

	rbl_sync_t st_reg;
	rbl_sync_t st_next;

	if (W < 1) begin : g_width_chk
		$error("rbl_sync: width must be positive");
	end

	always_comb begin
		st_next    = st_reg;
		st_next.s1 = d_i;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int i = 0; i < W; i++) begin
			if (st_reg.s2[i] == st_reg.s3[i]) begin
				st_next.q[i] = st_reg.s3[i];
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_reg <= '{s1: RST, s2: RST, s3: RST, q: RST};
		end else begin
			st_reg <= st_next;
		end
	end

	assign q_o = st_reg.q;
endmodule

/* hw/rbl_boot_rx.sv */
/*
 * Boot serial clock generator and 256-bit boot stream receiver.
 * Assumes supply_good and the serial data input already synchronised.
 */
`timescale 1ns/1ps
`include "rbl_params.svh"

module rbl_boot_rx #(
	parameter int DIV  = `RBL_SCLK_DIV,
	parameter int BITS = `RBL_BOOT_BITS
) (
	input  wire logic                      mclk_i,
	input  wire logic                      rst_i,
	input  wire logic                      supply_good_i,
	input  wire logic                      boot_serial_in_i,
	output logic                           boot_serial_clk_o,
	output logic                           done_o,
	output logic                           rsv_nz_o,
	output logic [`RBL_MODE_BITS-1:0]      mode_o
);
	import rbl_pkg::*;

	typedef struct packed {
		logic                      sclk;
		logic [$clog2(DIV)-1:0]    div;
		logic [$clog2(BITS):0]     nbit;
		logic                      done;
		logic                      rsv_nz;
		logic [`RBL_MODE_BITS-1:0] mode;
	} rbl_rx_t;

	rbl_rx_t st_reg;
	rbl_rx_t st_next;

	if (DIV < 4 || (DIV & (DIV - 1)) != 0) begin : g_div_chk
		$error("rbl_boot_rx: DIV must be a power of two >= 4");
	end
	if (BITS <= `RBL_MODE_BITS) begin : g_bits_chk
		$error("rbl_boot_rx: stream shorter than mode word");
	end

	always_comb begin
		st_next     = st_reg;
		st_next.div = st_reg.div + 1'b1;
		// High half then low half; the wrap to zero is the rising edge,
		// so the parked-high clock first rises a full period after supply
		st_next.sclk = (st_next.div < ($clog2(DIV))'(DIV / 2));
		// Sample just before the rising edge, after the bit has settled
		if (!st_reg.done && st_reg.div == ($clog2(DIV))'(DIV - 1)) begin
			if (st_reg.nbit < ($clog2(BITS)+1)'(`RBL_MODE_BITS)) begin
				st_next.mode[st_reg.nbit[3:0]] = boot_serial_in_i;
			end else if (boot_serial_in_i) begin
				st_next.rsv_nz = 1'b1;
			end
			st_next.nbit = st_reg.nbit + 1'b1;
			if (st_reg.nbit == ($clog2(BITS)+1)'(BITS - 1)) begin
				st_next.done = 1'b1;
			end
		end
		// Supply low: clock parked high, count restarts on the next rise
		if (!supply_good_i) begin
			st_next.sclk   = 1'b1;
			st_next.div    = '0;
			st_next.nbit   = '0;
			st_next.done   = 1'b0;
			st_next.rsv_nz = 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_reg <= '{sclk: 1'b1, div: '0, nbit: '0, done: 1'b0, rsv_nz: 1'b0,
				mode: `RBL_MODE_RESET};
		end else begin
			st_reg <= st_next;
		end
	end

	// First rise after DIV cycles, then one every DIV cycles
	assign boot_serial_clk_o = st_reg.sclk;
	assign done_o            = st_reg.done;
	assign rsv_nz_o          = st_reg.rsv_nz;
	assign mode_o            = st_reg.mode;
endmodule

/* hw/rbl_top.sv */
/*
 * Reset sequencer and boot-mode loader with an APB register slave.
 * Assumes pins arrive unsynchronised and an APB master on mclk_i.
 */
// Summary of operation
// - Stream read on supply rise, then PLL
// - Cold reset starts with Reset exception, Soft Reset if it begins during a warm reset
// - Warm reset keeps PLL, no stream reread
// - Warm reset gives Soft Reset exception
// - Every reset clears state machines, fetches vector
// - Exactly 256 boot bits captured serially
// - Serial clock high while supply low
// - First rise after 256, then every 256
// - Write-rate code picks data/idle pattern
// - Multiplier codes 0..6 give times 2..8
// - Non-block write: 0, 2, 3; 1 reserved
// - Timer routing and byte order select
// - Bus width bit: 0 wide, 1 narrow
// - Drive strength code to percent
// - Serial clock divides by 256, always driven
// - Pins tri-stated until restart/full_init release
`timescale 1ns/1ps
`include "rbl_params.svh"

module rbl_top #(
	parameter int PLL_LOCK_CYC = `RBL_PLL_LOCK_CYC
) (
	input  wire logic          mclk_i,
	input  wire logic          rst_i,
	input  wire logic          supply_good_i,
	input  wire logic          full_init_n_i,
	input  wire logic          restart_n_i,
	input  wire logic          boot_serial_in_i,
	input  wire rbl_pkg::rbl_apb_req_t apb_i,
	output rbl_pkg::rbl_apb_rsp_t      apb_o,
	output logic               boot_serial_clk_o,
	output rbl_pkg::rbl_cfg_t  cfg_o,
	output rbl_pkg::rbl_ctl_t  ctl_o
);
	import rbl_pkg::*;

	// ****************************************
	// Decode helpers
	// ****************************************
	function automatic logic [6:0] drive_pct(input logic [1:0] code);
		unique case (code)
			2'b10: drive_pct = 7'h64;
			2'b11: drive_pct = 7'h53;
			2'b00: drive_pct = 7'h43;
			2'b01: drive_pct = 7'h32;
		endcase
	endfunction

	// Data cycles then idle cycles of one repeat of the block-write pattern
	function automatic logic [4:0] wr_pattern(input logic [3:0] code);
		unique case (code)
			4'h0:    wr_pattern = {2'h1, 3'h0};
			4'h1:    wr_pattern = {2'h2, 3'h1};
			4'h2:    wr_pattern = {2'h2, 3'h2};
			4'h3:    wr_pattern = {2'h1, 3'h1};
			4'h4:    wr_pattern = {2'h2, 3'h3};
			4'h5:    wr_pattern = {2'h2, 3'h4};
			4'h6:    wr_pattern = {2'h1, 3'h2};
			4'h7:    wr_pattern = {2'h2, 3'h6};
			4'h8:    wr_pattern = {2'h1, 3'h3};
			default: wr_pattern = {2'h1, 3'h0};
		endcase
	endfunction

	function automatic logic apb_hit(input logic [11:0] a, input logic [11:0] ofs);
		apb_hit = (a == ofs);
	endfunction

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		rbl_state_t   state;
		logic         cold;
		logic [15:0]  lock_cnt;
		logic         sg_d;
		logic         cold_seen;
		logic         warm_seen;
		rbl_cfg_t     cfg;
		rbl_ctl_t     ctl;
		rbl_apb_rsp_t rsp;
	} rbl_top_t;

	rbl_top_t st_reg;
	rbl_top_t st_next;

	logic                      sg;
	logic                      fi_n;
	logic                      rs_n;
	logic                      sin;
	logic                      boot_done;
	logic                      rsv_nz;
	logic [`RBL_MODE_BITS-1:0] mode_bits;
	rbl_mode_t                 mode;
	logic                      access;
	logic [31:0]               rd_word;
	logic                      rd_ok;
	// Cause recorded this cycle; it beats a software clear
	logic                      cold_set;
	logic                      warm_set;

	if (PLL_LOCK_CYC < 1 || PLL_LOCK_CYC > 65535) begin : g_lock_chk
		$error("rbl_top: PLL_LOCK_CYC out of range");
	end

	// ****************************************
	// Pin synchronisers and stream receiver
	// ****************************************
	rbl_sync #(
		.W   (4),
		.RST (4'h0)
	) u_sync (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.d_i    ({supply_good_i, full_init_n_i, restart_n_i, boot_serial_in_i}),
		.q_o    ({sg, fi_n, rs_n, sin})
	);

	rbl_boot_rx #(
		.DIV  (`RBL_SCLK_DIV),
		.BITS (`RBL_BOOT_BITS)
	) u_rx (
		.mclk_i            (mclk_i),
		.rst_i             (rst_i),
		.supply_good_i     (sg),
		.boot_serial_in_i  (sin),
		.boot_serial_clk_o (boot_serial_clk_o),
		.done_o            (boot_done),
		.rsv_nz_o          (rsv_nz),
		.mode_o            (mode_bits)
	);

	assign mode = rbl_mode_t'(mode_bits);

	// ****************************************
	// Register read mux
	// ****************************************
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok   = 1'b1;
		if (apb_hit(apb_i.paddr, `RBL_OFS_CTRL)) begin
			rd_word = 32'h0000_0000;
		end else if (apb_hit(apb_i.paddr, `RBL_OFS_STATUS)) begin
			rd_word[`RBL_STAT_DONE_BIT] = boot_done;
			rd_word[`RBL_STAT_COLD_BIT] = st_reg.cold_seen;
			rd_word[`RBL_STAT_WARM_BIT] = st_reg.warm_seen;
			rd_word[`RBL_STAT_RSV_BIT]  = st_reg.cfg.rsv_err;
			rd_word[`RBL_STAT_ST_LSB +: 3] = st_reg.state;
		end else if (apb_hit(apb_i.paddr, `RBL_OFS_MODE)) begin
			rd_word[`RBL_MODE_BITS-1:0] = mode_bits;
		end else begin
			rd_ok = 1'b0;
		end
	end

	assign access = apb_i.psel && apb_i.penable && !st_reg.rsp.pready;

	// ****************************************
	// Sequencer, configuration and bus slave
	// ****************************************
	always_comb begin
		st_next      = st_reg;
		st_next.sg_d = sg;
		st_next.ctl.exc_reset = 1'b0;
		st_next.ctl.exc_soft  = 1'b0;
		cold_set              = 1'b0;
		warm_set              = 1'b0;

		unique case (st_reg.state)
			RBL_OFF: begin
				if (sg && !st_reg.sg_d) begin
					st_next.state = RBL_BOOT;
					st_next.cold  = 1'b1;
				end
			end
			RBL_BOOT: begin
				if (boot_done) begin
					// Decode once the whole stream is
					st_next.cfg.pll_mult    = {1'b0, mode.mult} + `RBL_MULT_BASE;
					st_next.cfg.big_end     = mode.big_end;
					st_next.cfg.timer_route = !mode.tmr_dis;
					st_next.cfg.bus32       = mode.bus32;
					st_next.cfg.drive_pct   = drive_pct(mode.drive);
					st_next.cfg.nbw         = mode.nbw;
					{st_next.cfg.wr_run, st_next.cfg.wr_idle} = wr_pattern(mode.wrate);
					// Reserved codes and nonzero reserved bits are flagged
					st_next.cfg.rsv_err = rsv_nz || mode.rsv0
						|| mode.mult == `RBL_MULT_RSV
						|| mode.wrate > `RBL_WRATE_MAX
						|| mode.nbw == `RBL_NBW_RSV;
					st_next.ctl.pll_enable = 1'b1;
					st_next.lock_cnt       = 16'h0000;
					st_next.state          = RBL_LOCK;
				end
			end
			RBL_LOCK: begin
				st_next.lock_cnt = st_reg.lock_cnt + 16'h0001;
				if (st_reg.lock_cnt == 16'(PLL_LOCK_CYC - 1)) begin
					st_next.state = RBL_HELD;
				end
			end
			RBL_HELD: begin
				if (fi_n) begin
					st_next.ctl.out_oe = 1'b1;
					st_next.state      = RBL_RSTW;
				end
			end
			RBL_RSTW: begin
				if (!fi_n) begin
					st_next.ctl.out_oe = 1'b0;
					st_next.state      = RBL_HELD;
				end else if (rs_n) begin
					st_next.ctl.bus_oe    = 1'b1;
					st_next.ctl.sm_reset  = 1'b0;
					st_next.ctl.exc_reset = st_reg.cold;
					st_next.ctl.exc_soft  = !st_reg.cold;
					cold_set              = st_reg.cold;
					warm_set              = !st_reg.cold;
					st_next.cold_seen     = st_reg.cold_seen || cold_set;
					st_next.warm_seen     = st_reg.warm_seen || warm_set;
					st_next.state         = RBL_RUN;
				end
			end
			RBL_RUN: begin
				if (!fi_n) begin
					st_next.ctl.bus_oe   = 1'b0;
					st_next.ctl.out_oe   = 1'b0;
					st_next.ctl.sm_reset = 1'b1;
					st_next.cold         = 1'b1;
					st_next.state        = RBL_HELD;
				end else if (!rs_n) begin
					// Warm: PLL and mode word kept, no reread
					st_next.ctl.bus_oe   = 1'b0;
					st_next.ctl.sm_reset = 1'b1;
					st_next.cold         = 1'b0;
					st_next.state        = RBL_RSTW;
				end
			end
			default: st_next.state = RBL_OFF;
		endcase

		// Supply loss always restarts the whole sequence
		if (!sg) begin
			st_next.state          = RBL_OFF;
			st_next.ctl.pll_enable = 1'b0;
			st_next.ctl.sm_reset   = 1'b1;
			st_next.ctl.bus_oe     = 1'b0;
			st_next.ctl.out_oe     = 1'b0;
		end

		// One wait state, so every answer comes from a flop
		st_next.rsp.pready  = access;
		st_next.rsp.pslverr = access && !rd_ok;
		if (access) begin
			st_next.rsp.prdata = apb_i.pwrite ? 32'h0000_0000 : rd_word;
		end
		if (apb_i.psel && apb_i.penable && st_reg.rsp.pready && apb_i.pwrite
			&& apb_hit(apb_i.paddr, `RBL_OFS_CTRL) && apb_i.pwdata[`RBL_CTRL_CLR_BIT]) begin
			// Clear loses to a cause being recorded in the same cycle
			st_next.cold_seen = cold_set;
			st_next.warm_seen = warm_set;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_reg <= '{
				state:     RBL_OFF,
				cold:      1'b1,
				lock_cnt:  16'h0000,
				sg_d:      1'b0,
				cold_seen: 1'b0,
				warm_seen: 1'b0,
				cfg:       '{pll_mult: `RBL_MULT_BASE, drive_pct: 7'h64, wr_run: 2'h1, default: '0},
				ctl:       '{sm_reset: 1'b1, default: 1'b0},
				rsp:       '0
			};
		end else begin
			st_reg <= st_next;
		end
	end

	assign apb_o = st_reg.rsp;
	assign cfg_o = st_reg.cfg;
	assign ctl_o = st_reg.ctl;
endmodule

/* sim/rbl_monitor.sv */
/*
 * Concurrent checks on the pins of the reset and boot-mode loader.
 * Assumes it is bound into rbl_top and sees only that module's ports.
 */
`timescale 1ns/1ps

module rbl_monitor #(
	parameter int PLL_LOCK_CYC = 64
) (
	input wire logic              mclk_i,
	input wire logic              rst_i,
	input wire logic              supply_good_i,
	input wire logic              full_init_n_i,
	input wire logic              restart_n_i,
	input wire logic              boot_serial_clk_o,
	input wire rbl_pkg::rbl_ctl_t ctl_o
);
	import rbl_pkg::*;

	// ****
	// Helper counters, cleared while the supply pin is low
	// ****
	logic [8:0] per_cnt;
	logic [8:0] rise_cnt;
	logic [9:0] sup_cnt;
	logic       clk_q;
	logic       per_ok;

	always_ff @(posedge mclk_i) begin
		clk_q <= boot_serial_clk_o;
		if (rst_i || !supply_good_i) begin
			per_cnt  <= 9'h000;
			rise_cnt <= 9'h000;
			sup_cnt  <= 10'h000;
			per_ok   <= 1'b0;
		end else begin
			if (sup_cnt != 10'h3FF) begin
				sup_cnt <= sup_cnt + 10'h001;
			end
			if (boot_serial_clk_o && !clk_q) begin
				per_cnt <= 9'h001;
				per_ok  <= 1'b1;
				if (rise_cnt != 9'h1FF) begin
					rise_cnt <= rise_cnt + 9'h001;
				end
			end else if (per_cnt != 9'h1FF) begin
				per_cnt <= per_cnt + 9'h001;
			end
		end
	end

	// ****
	// Assertions
	// ****
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	sclk_idle_a: assert property ((!supply_good_i) [*7] |-> boot_serial_clk_o)
		else $error("serial clock low with supply down");
	sclk_period_a: assert property ($rose(boot_serial_clk_o) && per_ok |-> per_cnt == 9'h100)
		else $error("serial clock period wrong");
	sclk_half_a: assert property ($fell(boot_serial_clk_o) && per_ok |-> per_cnt == 9'h080)
		else $error("serial clock high phase wrong");
	first_rise_a: assert property ($rose(boot_serial_clk_o) && supply_good_i
		|-> sup_cnt >= 10'h100)
		else $error("serial clock rose too early");
	first_bound_a: assert property ($rose(supply_good_i) |-> ##[256:266] $rose(boot_serial_clk_o))
		else $error("stream did not start");
	pll_late_a: assert property ($rose(ctl_o.pll_enable) |-> rise_cnt inside {9'h0FF, 9'h100})
		else $error("pll enabled before all bits");
	pll_keep_a: assert property ($fell(ctl_o.pll_enable) |-> !$past(supply_good_i, 4))
		else $error("pll dropped without supply loss");
	bus_hold_a: assert property ((!restart_n_i) [*7] |-> !ctl_o.bus_oe)
		else $error("bus pins driven in restart");
	out_hold_a: assert property ((!full_init_n_i) [*7] |-> !ctl_o.out_oe)
		else $error("output pins driven in full init");
	core_hold_a: assert property ((!restart_n_i) [*7] |-> ctl_o.sm_reset)
		else $error("core not held in restart");
	exc_start_a: assert property ($fell(ctl_o.sm_reset)
		|-> ##[0:1] (ctl_o.exc_reset || ctl_o.exc_soft))
		else $error("core started without exception");
	exc_pulse_a: assert property (ctl_o.exc_reset || ctl_o.exc_soft
		|=> !ctl_o.exc_reset && !ctl_o.exc_soft)
		else $error("exception pulse too long");
endmodule

bind rbl_top rbl_monitor #(.PLL_LOCK_CYC(PLL_LOCK_CYC)) rbl_monitor_inst (
	.mclk_i            (mclk_i),
	.rst_i             (rst_i),
	.supply_good_i     (supply_good_i),
	.full_init_n_i     (full_init_n_i),
	.restart_n_i       (restart_n_i),
	.boot_serial_clk_o (boot_serial_clk_o),
	.ctl_o             (ctl_o)
);

/* sim/rbl_boot_mem.sv */
/*
 * Serial boot memory model feeding the boot-mode stream.
 * Assumes supply_good and the serial clock are both seen on mclk_i.
 */
`timescale 1ns/1ps

module rbl_boot_mem #(
	parameter logic [14:0] MODE_WORD = 15'h0000
) (
	input  wire logic mclk_i,
	input  wire logic supply_good_i,
	input  wire logic boot_serial_clk_i,
	output logic      boot_serial_in_o
);
	// ****
	// Stream source
	// ****
	logic [255:0] stream;
	logic [8:0]   idx;
	logic         clk_q = 1'b1;
	logic         tog   = 1'b0;

	assign stream = {241'h0, MODE_WORD};

	always @(posedge mclk_i) begin
		clk_q <= boot_serial_clk_i;
		tog   <= ~tog;
		if (!supply_good_i) begin
			idx <= 9'h000;
		end else if (boot_serial_clk_i && !clk_q && !idx[8]) begin
			idx <= idx + 9'h001;
		end
	end

	// Toggles outside the frame so a stale bit cannot pass for data
	assign boot_serial_in_o = (supply_good_i && !idx[8]) ? stream[idx[7:0]] : tog;
endmodule

/* sim/tb_top.sv */
/*
 * Self-checking bench: power-on, boot stream, cold start, warm reset, APB.
 * Assumes the loader, its bound monitor and the boot memory model.
 */
`timescale 1ns/1ps

module tb_top;
	import rbl_pkg::*;

	// ****
	// Signals
	// ****
	localparam logic [14:0] MODE_WORD = 15'h77AE;
	localparam logic [21:0] EXP_CFG   = {4'h7, 3'h7, 7'h53, 2'h3, 2'h2, 3'h6, 1'b0};
	logic         mclk_i = 1'b0;
	logic         rst_i;
	logic         supply_good_i;
	logic         full_init_n_i;
	logic         restart_n_i;
	logic         boot_serial_in_i;
	logic         boot_serial_clk_o;
	rbl_apb_req_t apb_i;
	rbl_apb_rsp_t apb_o;
	rbl_cfg_t     cfg_o;
	rbl_ctl_t     ctl_o;
	int           error_cnt = 0;
	int           compares = 0;
	int           cyc = 0;
	int           cold_cnt = 0;
	int           warm_cnt = 0;

	always #2.5 mclk_i = ~mclk_i;

	rbl_top #(.PLL_LOCK_CYC(4)) rbl_top_inst (
		.mclk_i            (mclk_i),
		.rst_i             (rst_i),
		.supply_good_i     (supply_good_i),
		.full_init_n_i     (full_init_n_i),
		.restart_n_i       (restart_n_i),
		.boot_serial_in_i  (boot_serial_in_i),
		.apb_i             (apb_i),
		.apb_o             (apb_o),
		.boot_serial_clk_o (boot_serial_clk_o),
		.cfg_o             (cfg_o),
		.ctl_o             (ctl_o)
	);

	rbl_boot_mem #(.MODE_WORD(MODE_WORD)) rbl_boot_mem_inst (
		.mclk_i            (mclk_i),
		.supply_good_i     (supply_good_i),
		.boot_serial_clk_i (boot_serial_clk_o),
		.boot_serial_in_o  (boot_serial_in_i)
	);

	// ****
	// Tasks
	// ****
	task automatic check(input logic [31:0] got, input logic [31:0] exp_v);
		compares++;
		if (got !== exp_v) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp_v);
		end
	endtask

	task automatic bus_chk(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] msk, input logic [31:0] exp_d, input logic exp_e);
		int n;
		n = 0;
		apb_i <= '{1'b1, 1'b0, wr, a, d};
		@(posedge mclk_i);
		apb_i.penable <= 1'b1;
		do begin
			@(posedge mclk_i);
			n++;
		end while (apb_o.pready !== 1'b1 && n < 50);
		check({31'h0, apb_o.pready}, 32'h1);
		check(apb_o.prdata & msk, exp_d);
		check({31'h0, apb_o.pslverr}, {31'h0, exp_e});
		apb_i <= '0;
		@(posedge mclk_i);
	endtask

	task automatic print_verdict;
		$display("error_cnt %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Start pulses and hang guard
	always @(posedge mclk_i) begin
		cyc++;
		if (ctl_o.exc_reset === 1'b1) cold_cnt++;
		if (ctl_o.exc_soft === 1'b1) warm_cnt++;
		if (cyc == 80000) begin
			error_cnt++;
			print_verdict();
		end
	end

	// ****
	// Sequence
	// ****
	initial begin
		rst_i         = 1'b1;
		supply_good_i = 1'b0;
		full_init_n_i = 1'b0;
		restart_n_i   = 1'b0;
		apb_i         = '0;
		repeat (6) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (20) @(posedge mclk_i);
		check({31'h0, boot_serial_clk_o}, 32'h1);
		bus_chk(1'b0, 12'h004, 32'h0, 32'h79, 32'h00, 1'b0);
		bus_chk(1'b0, 12'h00C, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1);
		supply_good_i <= 1'b1;
		repeat (600) @(posedge mclk_i);
		bus_chk(1'b0, 12'h004, 32'h0, 32'h79, 32'h10, 1'b0);
		while (ctl_o.pll_enable !== 1'b1) @(posedge mclk_i);
		check({10'h0, cfg_o}, {10'h0, EXP_CFG});
		bus_chk(1'b0, 12'h008, 32'h0, 32'hFFFFFFFF, 32'h77AE, 1'b0);
		repeat (20) @(posedge mclk_i);
		bus_chk(1'b0, 12'h004, 32'h0, 32'h79, 32'h31, 1'b0);
		full_init_n_i <= 1'b1;
		repeat (10) @(posedge mclk_i);
		check({29'h0, ctl_o.out_oe, ctl_o.bus_oe, ctl_o.sm_reset}, 32'h5);
		repeat (64) @(posedge mclk_i);
		restart_n_i <= 1'b1;
		while (ctl_o.sm_reset !== 1'b0) @(posedge mclk_i);
		repeat (2) @(posedge mclk_i);
		check(32'(cold_cnt * 2 + warm_cnt), 32'h2);
		check({31'h0, ctl_o.bus_oe}, 32'h1);
		bus_chk(1'b0, 12'h004, 32'h0, 32'hFFFFFFFF, 32'h53, 1'b0);
		bus_chk(1'b1, 12'h000, 32'h1, 32'h0, 32'h0, 1'b0);
		bus_chk(1'b1, 12'h008, 32'h0, 32'h0, 32'h0, 1'b0);
		bus_chk(1'b1, 12'h010, 32'h1, 32'h0, 32'h0, 1'b1);
		bus_chk(1'b0, 12'h004, 32'h0, 32'hFFFFFFFF, 32'h51, 1'b0);
		bus_chk(1'b0, 12'h008, 32'h0, 32'hFFFFFFFF, 32'h77AE, 1'b0);
		restart_n_i <= 1'b0;
		repeat (64) @(posedge mclk_i);
		check({29'h0, ctl_o.pll_enable, ctl_o.bus_oe, ctl_o.sm_reset}, 32'h5);
		restart_n_i <= 1'b1;
		while (ctl_o.sm_reset !== 1'b0) @(posedge mclk_i);
		repeat (2) @(posedge mclk_i);
		check(32'(cold_cnt * 2 + warm_cnt), 32'h3);
		check({10'h0, cfg_o}, {10'h0, EXP_CFG});
		bus_chk(1'b0, 12'h004, 32'h0, 32'hFFFFFFFF, 32'h55, 1'b0);
		supply_good_i <= 1'b0;
		repeat (10) @(posedge mclk_i);
		check({28'h0, boot_serial_clk_o, ctl_o.pll_enable, ctl_o.bus_oe, ctl_o.out_oe},
			32'h8);
		print_verdict();
	end
endmodule
